// File: hw/hbd_defines.svh
`ifndef HBD_DEFINES_SVH
`define HBD_DEFINES_SVH
// Timing
`define HBD_CLK_HZ 50000000
`define HBD_CYC_PER_US (`HBD_CLK_HZ / 1000000)
`define HBD_WAKE_TIME_US 3000
`define HBD_RETRY_TIME_US 3000
`define HBD_OFF_TIME_US 20
`define HBD_WAKE_CYC (`HBD_WAKE_TIME_US * `HBD_CYC_PER_US)
`define HBD_RETRY_CYC (`HBD_RETRY_TIME_US * `HBD_CYC_PER_US)
`define HBD_OFF_CYC (`HBD_OFF_TIME_US * `HBD_CYC_PER_US)
`define HBD_CNT_W 18
`define HBD_MIX_LO_PCT 30
`define HBD_MIX_HI_PCT 60
// Decay select codes {hi, lo}
`define HBD_DECAY_MIX_LO 2'h1
`define HBD_DECAY_MIX_HI 2'h2
`define HBD_DECAY_FAST 2'h3
// Register offsets
`define HBD_REG_STATUS 8'h00
`define HBD_REG_MASK 8'h04
`define HBD_REG_STATE 8'h08
// Event field width and reset values
`define HBD_EV_W 6
`define HBD_STATUS_RST 6'h00
`define HBD_MASK_RST 6'h00
`endif

// File: hw/hbd_pkg.sv
package hbd_pkg;
  // Power sequencing states
  typedef enum logic [1:0] {PW_SLEEP, PW_WAKE, PW_ACTIVE} hbd_pwr_t;
  // Per-bridge regulation states
  typedef enum logic [1:0] {BR_RUN, BR_OFF, BR_RETRY} hbd_br_t;
  typedef logic [1:0] hbd_decay_t;
endpackage

// File: hw/hbd_br_if.sv
`timescale 1ns/1ps
// Control and status of one bridge between top and regulator
interface hbd_br_if;
  logic en;
  logic dir_in_a;
  logic dir_in_b;
  logic trip;
  logic overcurrent_guard;
  logic allow;
  logic [1:0] decay;
  logic hiz;
  logic hi_first;
  logic hi_second;
  logic regulating;
  logic ocp_hold;
  logic trip_evt;
  logic ocp_evt;
  modport ctl (output en, dir_in_a, dir_in_b, trip, overcurrent_guard, allow, decay,
    input hiz, hi_first, hi_second, regulating, ocp_hold, trip_evt, ocp_evt);
  modport br (input en, dir_in_a, dir_in_b, trip, overcurrent_guard, allow, decay,
    output hiz, hi_first, hi_second, regulating, ocp_hold, trip_evt, ocp_evt);
endinterface

// File: hw/hbd_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser; first stage feeds only the second
module hbd_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// File: hw/hbd_bridge.sv
`timescale 1ns/1ps
`include "hbd_defines.svh"
// One bridge: input decode, off-time regulation, overcurrent retry
module hbd_bridge import hbd_pkg::*; #(
  parameter int FIXED_OFF_TIME_CYC = `HBD_OFF_CYC,
  parameter int RETRY_CYC = `HBD_RETRY_CYC,
  parameter int CNT_W = `HBD_CNT_W
) (
  input wire logic clk,
  input wire logic reset,
  hbd_br_if.br bus
);
  localparam int FAST_LO = FIXED_OFF_TIME_CYC * `HBD_MIX_LO_PCT / 100;
  localparam int FAST_HI = FIXED_OFF_TIME_CYC * `HBD_MIX_HI_PCT / 100;
  hbd_br_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] pat_q, pat_d;
  logic trip_q;
  logic fast;
  function automatic logic cnt_at(logic [CNT_W-1:0] c, int n);
    return c == CNT_W'(n);
  endfunction
  // Next state; overcurrent beats regulation
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    pat_d = pat_q;
    bus.trip_evt = 1'b0;
    bus.ocp_evt = 1'b0;
    case (st_q)
      BR_RUN: begin
        if (bus.overcurrent_guard) begin
          st_d = BR_RETRY; // [RULE17]
          cnt_d = '0;
          bus.ocp_evt = 1'b1;
        end else if (bus.trip && bus.allow && bus.en) begin
          st_d = BR_OFF; // [RULE9] [RULE11]
          cnt_d = '0;
          pat_d = {bus.dir_in_a, bus.dir_in_b};
          bus.trip_evt = 1'b1;
        end
      end
      BR_OFF: begin
        if (bus.overcurrent_guard) begin
          st_d = BR_RETRY; // [RULE17]
          cnt_d = '0;
          bus.ocp_evt = 1'b1;
        end else if (!bus.allow) begin
          st_d = BR_RUN;
        end else if (bus.trip && !trip_q) begin
          cnt_d = '0; // [RULE18]
          bus.trip_evt = 1'b1;
        end else if (cnt_at(cnt_q, FIXED_OFF_TIME_CYC - 1)) begin
          st_d = BR_RUN; // [RULE10]
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      BR_RETRY: begin
        if (cnt_at(cnt_q, RETRY_CYC - 1)) st_d = BR_RUN; // [RULE17]
        else cnt_d = cnt_q + 1'b1;
      end
      default: st_d = BR_RUN;
    endcase
  end
  // Bridge drive; fast decay reverses the captured energising pattern
  always_comb begin
    case (bus.decay)
      `HBD_DECAY_FAST: fast = 1'b1; // [RULE16]
      `HBD_DECAY_MIX_LO: fast = cnt_q < CNT_W'(FAST_LO);
      `HBD_DECAY_MIX_HI: fast = cnt_q < CNT_W'(FAST_HI);
      default: fast = 1'b0;
    endcase
    bus.regulating = st_q == BR_OFF; // [RULE12]
    bus.ocp_hold = st_q == BR_RETRY;
    // Enable low releases the pins even inside an off-time
    bus.hiz = !bus.allow || st_q == BR_RETRY || !bus.en; // [RULE3]
    if (st_q == BR_OFF) begin
      if (fast && (pat_q[1] != pat_q[0])) {bus.hi_first, bus.hi_second} = ~pat_q;
      else {bus.hi_first, bus.hi_second} = 2'b00;
    end else begin
      {bus.hi_first, bus.hi_second} = {bus.dir_in_a, bus.dir_in_b}; // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= BR_RUN;
      cnt_q <= '0;
      pat_q <= 2'h0;
      trip_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pat_q <= pat_d;
      trip_q <= bus.trip;
    end
  end
endmodule

// File: hw/hbd_top.sv
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "hbd_defines.svh"
// Overview of operation
// RULE1: Sleep low three-states all outputs, biases off circuits, stops charge pump.
// RULE2: After sleep goes high, normal operation resumes within the wake time.
// RULE3: Enable low puts both outputs of that bridge in high impedance.
// RULE4: Enable high, both directions low: both outputs low, slow brake.
// RULE5: Enable high, first direction high only: first output high, second low.
// RULE6: Enable high, second direction high only: first output low, second high.
// RULE7: Enable high, both directions high: both outputs high, high brake.
// RULE8: Inputs are followed only while the bridge current is below threshold.
// RULE9: Current above threshold overrides inputs and forces decay for off-time.
// RULE10: After the off-time the bridge follows the inputs again.
// RULE11: Each bridge has its own threshold and independent regulation loop.
// RULE12: Each monitor output pulls low while its regulation loop is in control.
// RULE13: Fault output pulls low whenever any protection condition is present. The code keeps it released while in sleep.
// RULE14: Over-temperature or low supply three-states outputs until it clears.
// RULE15: Half-scale select low gives full threshold scale, high gives half.
// RULE16: Decay selects choose slow, 30% mixed, 60% mixed or fast during off-time.
// RULE17: Overcurrent disables the bridge, flags fault, holds it off for retry time.
// RULE18: A new trip during the off-time restarts the off-time interval.
// RULE19: Off-time is a cycle-count parameter; trip inputs are synchronised.
module hbd_top import hbd_pkg::*; #(
  parameter int FIXED_OFF_TIME_CYC = `HBD_OFF_CYC,
  parameter int WAKE_CYC = `HBD_WAKE_CYC,
  parameter int RETRY_CYC = `HBD_RETRY_CYC,
  parameter int CNT_W = `HBD_CNT_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sleep_n,
  input wire logic en_a,
  input wire logic dir_in_a_a,
  input wire logic dir_in_b_a,
  input wire logic en_b,
  input wire logic dir_in_a_b,
  input wire logic dir_in_b_b,
  input wire logic half_scale_sel,
  input wire logic decay_sel_lo,
  input wire logic decay_sel_hi,
  input wire logic trip_threshold_hit_a,
  input wire logic trip_threshold_hit_b,
  input wire logic overcurrent_guard_a,
  input wire logic overcurrent_guard_b,
  input wire logic over_temp_shutdown,
  input wire logic supply_low_lockout,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic bridge_out_first_a,
  output logic bridge_out_first_a_oe_n,
  output logic bridge_out_second_a,
  output logic bridge_out_second_a_oe_n,
  output logic bridge_out_first_b,
  output logic bridge_out_first_b_oe_n,
  output logic bridge_out_second_b,
  output logic bridge_out_second_b_oe_n,
  output logic reg_monitor_a,
  output logic reg_monitor_a_oe_n,
  output logic reg_monitor_b,
  output logic reg_monitor_b_oe_n,
  output logic fault_n,
  output logic fault_oe_n,
  output logic threshold_half,
  output logic charge_pump_en,
  output logic bias_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // One carrier per bridge keeps the two loops apart
  hbd_br_if br_if_a ();
  hbd_br_if br_if_b ();

  logic [1:0] trip_sync;
  hbd_pwr_t pw_q, pw_d;
  logic [CNT_W-1:0] wake_cnt_q, wake_cnt_d;
  logic tsd_q, supply_low_lockout_q;
  logic allow;
  logic fault_act;
  logic [`HBD_EV_W-1:0] events;
  logic [`HBD_EV_W-1:0] status_q, status_d;
  logic [`HBD_EV_W-1:0] mask_q, mask_d;
  logic [`HBD_EV_W-1:0] w1c;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [7:0] pins_q, pins_d;
  logic [7:0] pins_oe_n_q, pins_oe_n_d;
  logic scale_q, scale_d;
  logic pump_q, pump_d;
  logic bias_q, bias_d;
  logic od_low_q;

  // Address match, shared by write and read decode
  function automatic logic reg_hit(logic [7:0] a, logic [7:0] off);
    return a == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Trip comparator inputs

  // Comparators are analog and free running, so they cross in here
  hbd_sync #(
    .W(2)
  ) u_trip_sync (
    .clk(clk),
    .reset(reset),
    .d({trip_threshold_hit_b, trip_threshold_hit_a}),
    .q(trip_sync)
  ); // [RULE19]

  ////////////////////////////////////////////////////////////////////////////
  // Sleep and wake sequencing

  // Bridge outputs stay released through the whole wake interval
  always_comb begin
    pw_d = pw_q;
    wake_cnt_d = wake_cnt_q;
    case (pw_q)
      PW_SLEEP: begin
        wake_cnt_d = '0;
        if (sleep_n) pw_d = PW_WAKE;
      end
      PW_WAKE: begin
        if (!sleep_n) begin
          pw_d = PW_SLEEP; // [RULE1]
        end else if (wake_cnt_q == CNT_W'(WAKE_CYC - 1)) begin
          pw_d = PW_ACTIVE; // [RULE2]
        end else begin
          wake_cnt_d = wake_cnt_q + 1'b1;
        end
      end
      PW_ACTIVE: begin
        if (!sleep_n) pw_d = PW_SLEEP; // [RULE1]
      end
      default: pw_d = PW_SLEEP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pw_q <= PW_SLEEP;
      wake_cnt_q <= '0;
    end else begin
      pw_q <= pw_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection

  // Bridges may drive only when awake and no lockout is present
  assign allow = (pw_q == PW_ACTIVE) && !over_temp_shutdown
    && !supply_low_lockout; // [RULE14]

  // Fault stays released in sleep since the bias is off
  assign fault_act = (pw_q != PW_SLEEP) && (over_temp_shutdown
    || supply_low_lockout || br_if_a.ocp_hold || br_if_b.ocp_hold); // [RULE13]

  // Previous levels, for edge events only
  always_ff @(posedge clk) begin
    if (reset) begin
      tsd_q <= 1'b0;
      supply_low_lockout_q <= 1'b0;
    end else begin
      tsd_q <= over_temp_shutdown;
      supply_low_lockout_q <= supply_low_lockout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridge regulators

  // Bridge A inputs
  assign br_if_a.en = en_a;
  assign br_if_a.dir_in_a = dir_in_a_a;
  assign br_if_a.dir_in_b = dir_in_b_a;
  assign br_if_a.trip = trip_sync[0];
  assign br_if_a.overcurrent_guard = overcurrent_guard_a;
  assign br_if_a.allow = allow;
  assign br_if_a.decay = {decay_sel_hi, decay_sel_lo};

  // Bridge B inputs
  assign br_if_b.en = en_b;
  assign br_if_b.dir_in_a = dir_in_a_b;
  assign br_if_b.dir_in_b = dir_in_b_b;
  assign br_if_b.trip = trip_sync[1];
  assign br_if_b.overcurrent_guard = overcurrent_guard_b;
  assign br_if_b.allow = allow;
  assign br_if_b.decay = {decay_sel_hi, decay_sel_lo};

  // Two independent loops, one per bridge
  hbd_bridge #(
    .FIXED_OFF_TIME_CYC(FIXED_OFF_TIME_CYC),
    .RETRY_CYC(RETRY_CYC),
    .CNT_W(CNT_W)
  ) u_bridge_a (
    .clk(clk),
    .reset(reset),
    .bus(br_if_a)
  ); // [RULE11]

  hbd_bridge #(
    .FIXED_OFF_TIME_CYC(FIXED_OFF_TIME_CYC),
    .RETRY_CYC(RETRY_CYC),
    .CNT_W(CNT_W)
  ) u_bridge_b (
    .clk(clk),
    .reset(reset),
    .bus(br_if_b)
  ); // [RULE11]

  ////////////////////////////////////////////////////////////////////////////
  // Pin registers

  // Pin order: first_a, second_a, first_b, second_b, mon_a, mon_b, fault
  always_comb begin
    pins_d = 8'h00;
    pins_oe_n_d = 8'hff;
    pins_d[0] = br_if_a.hi_first;
    pins_d[1] = br_if_a.hi_second;
    pins_d[2] = br_if_b.hi_first;
    pins_d[3] = br_if_b.hi_second;
    pins_oe_n_d[1:0] = {2{br_if_a.hiz}}; // [RULE1] [RULE3] [RULE14]
    pins_oe_n_d[3:2] = {2{br_if_b.hiz}}; // [RULE1] [RULE3] [RULE14]
    pins_oe_n_d[4] = !br_if_a.regulating; // [RULE12]
    pins_oe_n_d[5] = !br_if_b.regulating; // [RULE12]
    pins_oe_n_d[6] = !fault_act; // [RULE13] [RULE17]
    scale_d = half_scale_sel; // [RULE15]
    pump_d = pw_d != PW_SLEEP; // [RULE1]
    bias_d = pw_d != PW_SLEEP; // [RULE1]
  end

  // Reset state leaves every pin released and the pump off
  always_ff @(posedge clk) begin
    if (reset) begin
      pins_q <= 8'h00;
      pins_oe_n_q <= 8'hff;
      scale_q <= 1'b0;
      pump_q <= 1'b0;
      bias_q <= 1'b0;
      od_low_q <= 1'b0;
    end else begin
      pins_q <= pins_d;
      pins_oe_n_q <= pins_oe_n_d;
      scale_q <= scale_d;
      pump_q <= pump_d;
      bias_q <= bias_d;
      od_low_q <= 1'b0;
    end
  end

  // Open-drain pins only ever pull low
  assign bridge_out_first_a = pins_q[0];
  assign bridge_out_second_a = pins_q[1];
  assign bridge_out_first_b = pins_q[2];
  assign bridge_out_second_b = pins_q[3];
  assign bridge_out_first_a_oe_n = pins_oe_n_q[0];
  assign bridge_out_second_a_oe_n = pins_oe_n_q[1];
  assign bridge_out_first_b_oe_n = pins_oe_n_q[2];
  assign bridge_out_second_b_oe_n = pins_oe_n_q[3];
  assign reg_monitor_a = od_low_q;
  assign reg_monitor_b = od_low_q;
  assign fault_n = od_low_q;
  assign reg_monitor_a_oe_n = pins_oe_n_q[4];
  assign reg_monitor_b_oe_n = pins_oe_n_q[5];
  assign fault_oe_n = pins_oe_n_q[6];
  assign threshold_half = scale_q;
  assign charge_pump_en = pump_q;
  assign bias_en = bias_q;

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt

  // Lockout events fire on the onset only
  assign events = {supply_low_lockout & ~supply_low_lockout_q, over_temp_shutdown & ~tsd_q,
    br_if_b.ocp_evt, br_if_a.ocp_evt, br_if_b.trip_evt, br_if_a.trip_evt};

  // Set beats clear so an event in the clearing cycle survives
  always_comb begin
    w1c = '0;
    mask_d = mask_q;
    if (reg_wr && reg_hit(reg_addr, `HBD_REG_STATUS)) w1c = reg_wdata[`HBD_EV_W-1:0];
    if (reg_wr && reg_hit(reg_addr, `HBD_REG_MASK)) mask_d = reg_wdata[`HBD_EV_W-1:0];
    status_d = (status_q & ~w1c) | events;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= `HBD_STATUS_RST;
      mask_q <= `HBD_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  // Registered so a clear never glitches the pin
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  // Data valid only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_hit(reg_addr, `HBD_REG_STATUS)) begin
        rdata_d[`HBD_EV_W-1:0] = status_q;
      end else if (reg_hit(reg_addr, `HBD_REG_MASK)) begin
        rdata_d[`HBD_EV_W-1:0] = mask_q;
      end else if (reg_hit(reg_addr, `HBD_REG_STATE)) begin
        rdata_d[7:0] = {br_if_b.ocp_hold, br_if_a.ocp_hold, fault_act,
          br_if_b.regulating, br_if_a.regulating, allow, pw_q};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) rdata_q <= 32'h0000_0000;
    else rdata_q <= rdata_d;
  end

  // Idle reads show zero, so stale data never lingers
  assign reg_rdata = rdata_q;

endmodule

// File: sim/hbd_top_props.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Pin-level checker for bridge A plus the shared protection pins
module hbd_top_props #(
  parameter int FIXED_OFF_TIME_CYC = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sleep_n,
  input wire logic en_a,
  input wire logic dir_in_a_a,
  input wire logic dir_in_b_a,
  input wire logic half_scale_sel,
  input wire logic trip_threshold_hit_a,
  input wire logic overcurrent_guard_a,
  input wire logic over_temp_shutdown,
  input wire logic supply_low_lockout,
  input wire logic bridge_out_first_a,
  input wire logic bridge_out_first_a_oe_n,
  input wire logic bridge_out_second_a,
  input wire logic bridge_out_second_a_oe_n,
  input wire logic reg_monitor_a_oe_n,
  input wire logic fault_oe_n,
  input wire logic threshold_half,
  input wire logic charge_pump_en,
  input wire logic bias_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic hiz_a;
  logic drv_a;
  logic [7:0] low_d;
  logic [7:0] low_q;
  // Pin summaries of bridge A
  assign hiz_a = bridge_out_first_a_oe_n && bridge_out_second_a_oe_n;
  assign drv_a = !bridge_out_first_a_oe_n && !bridge_out_second_a_oe_n;
  // Length of the current monitor pull; wraps past 255 cycles, shorter than the 1000-cycle default off-time
  always_comb low_d = reg_monitor_a_oe_n ? 8'h00 : low_q + 8'h01;
  always_ff @(posedge clk) low_q <= reset ? 8'h00 : low_d;
  ////////////////////////////////////////////////////////////////////////////////
  sleep_off_a: assert property (!sleep_n [*3] |-> !charge_pump_en && !bias_en && hiz_a)
    else $error("sleep left bridge or supplies on");
  en_off_a: assert property (!en_a [*2] |-> hiz_a)
    else $error("disabled bridge still driven");
  follow_in_a: assert property (drv_a && reg_monitor_a_oe_n && $past(reg_monitor_a_oe_n)
    |-> {bridge_out_first_a, bridge_out_second_a} == $past({dir_in_a_a, dir_in_b_a}))
    else $error("outputs do not follow direction inputs");
  trip_take_a: assert property ($rose(trip_threshold_hit_a) && en_a && drv_a && sleep_n
    && reg_monitor_a_oe_n |-> ##4 !reg_monitor_a_oe_n) else $error("trip not taken");
  off_len_a: assert property ($rose(reg_monitor_a_oe_n) |-> low_q >= FIXED_OFF_TIME_CYC)
    else $error("off-time ended early");
  ocp_hold_a: assert property ($rose(overcurrent_guard_a) && sleep_n
    |-> ##2 hiz_a && !fault_oe_n) else $error("overcurrent not handled");
  prot_hiz_a: assert property (((over_temp_shutdown || supply_low_lockout) && sleep_n) [*3]
    |-> hiz_a && !fault_oe_n) else $error("protection did not three-state");
  scale_copy_a: assert property (!$past(reset) |-> threshold_half == $past(half_scale_sel))
    else $error("scale select not applied");
  // Main scenarios reached
  cover property ($fell(reg_monitor_a_oe_n));
  cover property ($rose(overcurrent_guard_a));
  cover property ($rose(over_temp_shutdown));
endmodule

// File: sim/hbd_ctl_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far-side motor controller: holds enable and direction levels of both bridges
module hbd_ctl_model (
  input wire logic clk,
  input wire logic load,
  input wire logic [5:0] pat,
  output logic en_a,
  output logic dir_in_a_a,
  output logic dir_in_b_a,
  output logic en_b,
  output logic dir_in_a_b,
  output logic dir_in_b_b
);
  // Levels change only just after an edge, like a clocked controller
  initial {en_a, dir_in_a_a, dir_in_b_a, en_b, dir_in_a_b, dir_in_b_b} = 6'h00;
  always @(posedge clk) begin
    if (load) begin
      {en_a, dir_in_a_a, dir_in_b_a, en_b, dir_in_a_b, dir_in_b_b} <= pat;
    end
  end
endmodule

// File: sim/hbd_top_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module hbd_top_test;
  localparam int FIXED_OFF_TIME_CYC = 8;
  logic clk = 1'b0, reset = 1'b1, sleep_n = 1'b1, half_scale_sel = 1'b0;
  logic decay_sel_lo = 1'b0, decay_sel_hi = 1'b0, load = 1'b0;
  logic trip_threshold_hit_a = 1'b0, trip_threshold_hit_b = 1'b0;
  logic overcurrent_guard_a = 1'b0, overcurrent_guard_b = 1'b0;
  logic over_temp_shutdown = 1'b0, supply_low_lockout = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rnd = 32'hfe2c;
  logic reg_wr = 1'b0, reg_rd = 1'b0, irq, fault_n, fault_oe_n;
  logic [5:0] pat = 6'h00;
  logic en_a, dir_in_a_a, dir_in_b_a, en_b, dir_in_a_b, dir_in_b_b;
  logic bridge_out_first_a, bridge_out_first_a_oe_n, bridge_out_second_a;
  logic bridge_out_second_a_oe_n, bridge_out_first_b, bridge_out_first_b_oe_n;
  logic bridge_out_second_b, bridge_out_second_b_oe_n, reg_monitor_a, reg_monitor_a_oe_n;
  logic reg_monitor_b, reg_monitor_b_oe_n, threshold_half, charge_pump_en, bias_en;
  int n_errors = 0, checks = 0;
  int fexp[4] = '{0, FIXED_OFF_TIME_CYC * 30 / 100, FIXED_OFF_TIME_CYC * 60 / 100, FIXED_OFF_TIME_CYC};

  hbd_top #(.FIXED_OFF_TIME_CYC(FIXED_OFF_TIME_CYC), .WAKE_CYC(8), .RETRY_CYC(8)) dut_u (.*);
  hbd_ctl_model ctl_u (.*);

  // Free-running 50 MHz clock
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Enable/direction truth table: {oe_n first, oe_n second, first, second}
  function automatic logic [3:0] exp_pins(input logic [2:0] p);
    return p[2] ? {2'b00, p[1:0]} : 4'b1100;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic set_pat(input logic [5:0] p);
    @(posedge clk);
    load <= 1'b1;
    pat <= p;
    @(posedge clk);
    load <= 1'b0;
    at(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // Bounded wait for bridge A to drive again
  task automatic wait_drv(input int n);
    int i;
    for (i = 0; i < n && bridge_out_first_a_oe_n !== 1'b0; i++) @(negedge clk);
    chk(bridge_out_first_a_oe_n, 0);
  endtask
  task automatic summarize;
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    int i, k, f;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    set_pat(6'h2d);
    wait_drv(20);
    for (k = 0; k < 24; k++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      half_scale_sel <= rnd[6];
      set_pat(rnd[5:0]);
      chk({bridge_out_first_a_oe_n, bridge_out_second_a_oe_n, bridge_out_first_a & en_a,
        bridge_out_second_a & en_a}, exp_pins(rnd[5:3]));
      chk({bridge_out_first_b_oe_n, bridge_out_second_b_oe_n, bridge_out_first_b & en_b,
        bridge_out_second_b & en_b}, exp_pins(rnd[2:0]));
      chk(threshold_half, rnd[6]);
    end
    // Regulation in every decay mode, bridge A forward, bridge B untouched
    set_pat(6'h2d);
    wr(8'h04, 32'h3f);
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      {decay_sel_hi, decay_sel_lo} <= 2'(k);
      trip_threshold_hit_a <= 1'b1;
      @(posedge clk);
      trip_threshold_hit_a <= 1'b0;
      at(3);
      chk(reg_monitor_b_oe_n, 1);
      chk(irq, 1);
      i = 0;
      f = 0;
      while (reg_monitor_a_oe_n === 1'b0 && i < 40) begin
        f += ({bridge_out_first_a, bridge_out_second_a} === 2'b10);
        i++;
        @(negedge clk);
      end
      chk(i, FIXED_OFF_TIME_CYC);
      chk(f, fexp[k]);
      at(1);
      chk({bridge_out_first_a_oe_n, bridge_out_second_a_oe_n, bridge_out_first_a,
        bridge_out_second_a}, 4'b0001);
      rd(8'h00, d);
      chk(d[0], 1);
      wr(8'h00, 32'h1);
      rd(8'h00, d);
      chk({d[0], irq}, 2'b00);
    end
    // Second trip inside the off-time restarts it; counted from the second pulse
    @(posedge clk);
    trip_threshold_hit_a <= 1'b1;
    @(posedge clk);
    trip_threshold_hit_a <= 1'b0;
    repeat (6) @(posedge clk);
    trip_threshold_hit_a <= 1'b1;
    @(posedge clk);
    trip_threshold_hit_a <= 1'b0;
    @(negedge clk);
    i = 0;
    while (reg_monitor_a_oe_n === 1'b0 && i < 40) begin
      i++;
      @(negedge clk);
    end
    chk(i, FIXED_OFF_TIME_CYC + 3);
    // Overcurrent with its interrupt masked
    wr(8'h04, 32'h0);
    @(posedge clk);
    overcurrent_guard_a <= 1'b1;
    @(posedge clk);
    overcurrent_guard_a <= 1'b0;
    at(1);
    chk({bridge_out_first_a_oe_n, bridge_out_second_a_oe_n, fault_oe_n}, 3'b110);
    chk(irq, 0);
    chk({reg_monitor_a, reg_monitor_b, fault_n}, 3'b000);
    wait_drv(30);
    rd(8'h00, d);
    chk(d[2], 1);
    // Over-temperature, then low supply
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      {supply_low_lockout, over_temp_shutdown} <= 2'(k + 1);
      at(3);
      chk({bridge_out_first_a_oe_n, bridge_out_first_b_oe_n, fault_oe_n}, 3'b110);
      @(posedge clk);
      {supply_low_lockout, over_temp_shutdown} <= 2'b00;
      wait_drv(20);
    end
    rd(8'h00, d);
    chk(d[5:4], 2'b11);
    // Sleep and wake
    @(posedge clk);
    sleep_n <= 1'b0;
    at(3);
    chk({charge_pump_en, bias_en, bridge_out_first_a_oe_n, bridge_out_second_b_oe_n}, 4'h3);
    @(posedge clk);
    sleep_n <= 1'b1;
    wait_drv(20);
    rd(8'h08, d);
    chk(d, 32'h6);
    rd(8'h10, d);
    chk(d, 0);
    summarize();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule

bind hbd_top hbd_top_props #(.FIXED_OFF_TIME_CYC(FIXED_OFF_TIME_CYC)) props_u (.*);
